// ==== hw/bic_channel.sv ====
/*
 * Buffered I/O data channel: instruction decode, direct transfers and
 * block transfers between peripherals and storage.
 * Assumes host, peripheral and storage signals are synchronous to the
 * 100 MHz sys_clk_i and that storage read data stand with resume and
 * through the cycle after it, when the resume flag is seen.
 */
module bic_channel
    import bic_pkg::*;
(
    input  wire logic        sys_clk_i,      // System clock
    input  wire logic        rst_i,          // Sync reset, high
    input  wire logic        mclr_i,         // Host master clear
    input  wire logic        host_wr_i,      // Host write strobe
    input  wire logic        host_rd_i,      // Host read strobe
    input  wire logic [15:0] host_q_i,       // Instruction word
    input  wire logic [15:0] host_a_i,       // Accumulator word in
    output logic      [15:0] host_a_o,       // Accumulator word out
    output logic             host_reply_o,   // Host acknowledge
    output logic             host_reject_o,  // Host refusal
    output logic      [15:0] per_q_o,        // Instruction to periph
    output logic      [15:0] per_data_o,     // Data to peripheral
    input  wire logic [15:0] per_data_i,     // Data from peripheral
    output logic             per_read_o,     // Peripheral read strobe
    output logic             per_write_o,    // Peripheral write strobe
    input  wire logic        per_reply_i,    // Peripheral acknowledge
    input  wire logic        per_reject_i,   // Peripheral refusal
    input  wire logic        per_priority_i, // Peripheral wants speed
    output logic             buf_active_o,   // Buffered op running
    output logic             priority_o,     // Hold storage access
    output logic             mem_req_o,      // Storage request
    input  wire logic        mem_resume_i,   // Storage resume
    output logic      [15:0] mem_addr_o,     // Storage address
    output logic      [15:0] mem_wdata_o,    // Storage write data
    output logic             mem_we_o,       // Storage write
    output logic             ctl_word_o,     // Control word fetch
    input  wire logic [15:0] mem_rdata_i,    // Storage read data
    input  wire logic        mem_protect_i,  // Protection violation
    input  wire logic        scan_in_i,      // Ring input
    output logic             scan_out_o,     // Ring output
    input  wire logic [2:0]  ring_pos_i      // Ring position select
);

    bic_chan_st_t s;
    bic_chan_st_t n;
    bic_scan_if   sb ();
    logic [4:0]   op;
    logic [15:0]  nxt;
    logic [15:0]  st_word;
    logic         busy;
    logic         hreq;
    logic         set_eoo;
    logic         set_prot;

    ////////////////////////////////////////////////////////////////////////
    // Storage-access ring stage
    bic_scan_stage u_scan (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .mclr_i       (mclr_i),
        .scan_in_i    (scan_in_i),
        .ring_pos_i   (ring_pos_i),
        .mem_resume_i (mem_resume_i),
        .mem_req_o    (mem_req_o),
        .scan_out_o   (scan_out_o),
        .sb           (sb)
    );

    assign sb.need_set = s.nset;
    assign sb.abort    = s.abort;
    assign sb.hold     = s.hacc;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n        = s;
        op       = op_of(host_q_i);
        busy     = (s.st != S_IDLE);
        hreq     = host_wr_i | host_rd_i;
        nxt      = s.sa + ADDR_STEP;
        set_eoo  = 1'b0;
        set_prot = 1'b0;
        n.reply  = 1'b0;
        n.reject = 1'b0;
        n.nset   = 1'b0;
        n.abort  = 1'b0;
        st_word  = WORD_ZERO;
        st_word[ST_REPLY]  = s.drep;
        st_word[ST_REJECT] = s.drej;
        st_word[ST_PROT]   = s.prot;
        st_word[ST_EOO]    = s.eoo;
        st_word[ST_IRQ]    = s.eoo;
        st_word[ST_BUSY]   = busy;
        st_word[ST_READY]  = 1'b1;

        // Transfer engine
        case (s.st)
            S_IDLE: begin
            end
            S_DIR: begin
                if (per_reply_i) begin
                    n.pread  = 1'b0;
                    n.pwrite = 1'b0;
                    n.reply  = 1'b1;
                    n.drep   = 1'b1;
                    n.drej   = 1'b0;
                    if (s.pread) begin
                        n.aout = per_data_i;
                    end
                    n.st = S_PWAIT;
                end else if (per_reject_i) begin
                    n.pread  = 1'b0;
                    n.pwrite = 1'b0;
                    n.reject = 1'b1;
                    n.drep   = 1'b0;
                    n.drej   = 1'b1;
                    n.st     = S_PWAIT;
                end
            end
            S_FETCH: begin
                if (sb.done) begin
                    n.hold   = mem_rdata_i;
                    n.ctl    = 1'b0;
                    set_prot = mem_protect_i;
                    n.st     = S_STEP;
                end
            end
            S_STEP: begin
                n.sa = nxt;
                if (nxt == s.hold) begin
                    n.st    = S_IDLE;
                    n.bact  = 1'b0;
                    n.hacc  = 1'b0;
                    set_eoo = 1'b1;
                end else begin
                    if (s.din) begin
                        n.pread = 1'b1;
                        n.st    = S_PER;
                    end else begin
                        n.nset  = 1'b1;
                        n.maddr = nxt;
                        n.mwe   = 1'b0;
                        n.st    = S_MEM;
                    end
                end
            end
            S_MEM: begin
                if (sb.done) begin
                    n.mwe    = 1'b0;
                    set_prot = mem_protect_i;
                    if (s.din) begin
                        n.st = S_STEP;
                    end else begin
                        // Word waits here until the peripheral takes it
                        n.x      = mem_rdata_i;
                        n.pdata  = mem_rdata_i;
                        n.pwrite = 1'b1;
                        n.st     = S_PER;
                    end
                end
            end
            S_PER: begin
                // A refusal leaves the strobe up, so the word is retried
                if (per_reply_i) begin
                    n.pread  = 1'b0;
                    n.pwrite = 1'b0;
                    n.drep   = 1'b1;
                    n.drej   = 1'b0;
                    if (s.din) begin
                        n.x = per_data_i;
                    end
                    n.st = S_PWAIT;
                end else if (per_reject_i) begin
                    n.drej = 1'b1;
                end
            end
            S_PWAIT: begin
                // No new strobe until the acknowledge has dropped
                if (!per_reply_i && !per_reject_i) begin
                    if (!s.bact) begin
                        n.st = S_IDLE;
                    end else if (s.din) begin
                        n.nset  = 1'b1;
                        n.maddr = s.sa;
                        n.mwd   = s.x;
                        n.mwe   = 1'b1;
                        n.st    = S_MEM;
                    end else begin
                        n.st = S_STEP;
                    end
                end
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase

        // Next value, so the flag drops together with buffer active
        if (n.bact && per_priority_i) begin
            n.hacc = 1'b1;
        end

        // Host commands; a terminate overrides the engine only while buffer active is set
        if (hreq) begin
            if (is_direct(host_q_i)) begin
                if (busy) begin
                    n.reject = 1'b1;
                end else begin
                    n.f      = host_q_i;
                    n.pread  = host_rd_i;
                    n.pwrite = host_wr_i;
                    n.pdata  = host_a_i;
                    n.st     = S_DIR;
                end
            end else begin
                case (op)
                    OP_BUF_IN, OP_BUF_OUT: begin
                        if (busy || host_rd_i) begin
                            n.reject = 1'b1;
                        end else begin
                            n.f     = host_q_i;
                            n.sa    = host_a_i;
                            n.maddr = host_a_i;
                            n.mwe   = 1'b0;
                            n.ctl   = 1'b1;
                            n.bact  = 1'b1;
                            n.din   = (op == OP_BUF_IN);
                            n.nset  = 1'b1;
                            n.eoo   = 1'b0;
                            n.reply = 1'b1;
                            n.st    = S_FETCH;
                        end
                    end
                    OP_CUR_ADDR: begin
                        n.aout  = s.sa;
                        n.reply = 1'b1;
                    end
                    OP_STATUS: begin
                        n.aout  = st_word;
                        n.reply = 1'b1;
                        n.eoo   = 1'b0;
                        n.prot  = 1'b0;
                    end
                    OP_TERMINATE: begin
                        n.aout  = s.sa;
                        n.reply = 1'b1;
                        if (s.bact) begin
                            n.st     = S_IDLE;
                            n.bact   = 1'b0;
                            n.hacc   = 1'b0;
                            n.pread  = 1'b0;
                            n.pwrite = 1'b0;
                            n.mwe    = 1'b0;
                            n.ctl    = 1'b0;
                            n.abort  = 1'b1;
                        end
                    end
                    default: begin
                        n.reject = 1'b1;
                    end
                endcase
            end
        end

        // Hardware events win over a clear in the same cycle
        if (set_eoo) begin
            n.eoo = 1'b1;
        end
        if (set_prot) begin
            n.prot = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || mclr_i) begin
            s <= CHAN_RST;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register
    assign host_a_o      = s.aout;
    assign host_reply_o  = s.reply;
    assign host_reject_o = s.reject;
    assign per_q_o       = s.f;
    assign per_data_o    = s.pdata;
    assign per_read_o    = s.pread;
    assign per_write_o   = s.pwrite;
    assign buf_active_o  = s.bact;
    assign priority_o    = s.hacc;
    assign mem_addr_o    = s.maddr;
    assign mem_wdata_o   = s.mwd;
    assign mem_we_o      = s.mwe;
    assign ctl_word_o    = s.ctl;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i || mclr_i);

    sequence s_buf_start;
        host_wr_i && !host_rd_i && !busy && !is_direct(host_q_i)
            && (op == OP_BUF_IN || op == OP_BUF_OUT);
    endsequence

    sequence s_fetch_done;
        s.st == S_FETCH && sb.done && !hreq;
    endsequence

    a_start_loads_addr: assert property (
        s_buf_start |=> s.st == S_FETCH && mem_addr_o == $past(host_a_i)
            && ctl_word_o && buf_active_o)
        else $error("buffered start did not load start address");

    a_fetch_loads_hold: assert property (
        s_fetch_done |=> s.hold == $past(mem_rdata_i) && !ctl_word_o
            && s.st == S_STEP)
        else $error("control word not held");

    a_end_on_equal: assert property (
        s.st == S_STEP && nxt == s.hold && !hreq
            |=> s.st == S_IDLE && !buf_active_o && s.eoo)
        else $error("block did not end on equal address");

    a_step_on_unequal: assert property (
        s.st == S_STEP && nxt != s.hold && !s.din && !hreq
            |=> s.sa == $past(nxt) && mem_addr_o == $past(nxt)
            && s.nset && s.st == S_MEM)
        else $error("address not stepped to storage");

    a_busy_refused: assert property (
        hreq && busy && is_direct(host_q_i) |=> host_reject_o && !host_reply_o)
        else $error("busy channel accepted a direct operation");

    a_active_during_buf: assert property (
        s.st inside {S_FETCH, S_STEP, S_MEM} |-> buf_active_o)
        else $error("buffer active missing during buffered operation");

    a_instr_held: assert property (
        s.bact && $past(s.bact) |-> $stable(per_q_o))
        else $error("instruction changed during buffered operation");

    a_addr_readback: assert property (
        host_rd_i && !is_direct(host_q_i) && op == OP_CUR_ADDR
            |=> host_reply_o && host_a_o == $past(s.sa))
        else $error("current address not returned");

    a_prot_sets: assert property (
        s.st inside {S_FETCH, S_MEM} && sb.done && mem_protect_i |=> s.prot)
        else $error("protection fault not flagged");

endmodule : bic_channel

// ==== include/bic_pkg.sv ====
/*
 * Shared constants, types and decode helpers of the buffered I/O channel.
 * Assumes one 100 MHz clock and a synchronous, active-high reset.
 */
package bic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Word layout
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned OP_MSB   = 15;
    localparam int unsigned OP_LSB   = 11;
    localparam int unsigned CONT_BIT = 15;
    localparam int unsigned MAX_PER  = 8;

    // Operation field codes
    localparam logic [4:0] OP_BUF_IN    = 5'h01;
    localparam logic [4:0] OP_BUF_OUT   = 5'h02;
    localparam logic [4:0] OP_CUR_ADDR  = 5'h03;
    localparam logic [4:0] OP_STATUS    = 5'h04;
    localparam logic [4:0] OP_TERMINATE = 5'h05;

    // Status word bit positions
    localparam int unsigned ST_REPLY  = 9;
    localparam int unsigned ST_REJECT = 8;
    localparam int unsigned ST_PROT   = 6;
    localparam int unsigned ST_EOO    = 4;
    localparam int unsigned ST_IRQ    = 2;
    localparam int unsigned ST_BUSY   = 1;
    localparam int unsigned ST_READY  = 0;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_STEP = 16'h0001;

    // Ring position selector codes; any other code acts as middle
    localparam logic [2:0] POS_FIRST  = 3'h0;
    localparam logic [2:0] POS_MIDDLE = 3'h1;
    localparam logic [2:0] POS_LAST   = 3'h2;
    localparam logic [2:0] POS_ONE    = 3'h3;
    localparam logic [2:0] POS_OUT    = 3'h4;

    typedef enum logic [2:0] {
        S_IDLE, S_DIR, S_FETCH, S_STEP, S_MEM, S_PER, S_PWAIT
    } bic_state_t;

    typedef struct packed {
        bic_state_t  st;
        logic [15:0] f;
        logic [15:0] x;
        logic [15:0] sa;
        logic [15:0] hold;
        logic [15:0] aout;
        logic [15:0] pdata;
        logic [15:0] maddr;
        logic [15:0] mwd;
        logic        reply;
        logic        reject;
        logic        pread;
        logic        pwrite;
        logic        mwe;
        logic        bact;
        logic        ctl;
        logic        din;
        logic        nset;
        logic        abort;
        logic        hacc;
        logic        eoo;
        logic        prot;
        logic        drep;
        logic        drej;
    } bic_chan_st_t;

    typedef struct packed {
        logic scan;
        logic out;
        logic need;
        logic halt;
        logic resm;
    } bic_scan_st_t;

    localparam bic_chan_st_t CHAN_RST = '0;
    localparam bic_scan_st_t SCAN_RST = '0;

    function automatic logic [4:0] op_of(input logic [15:0] q);
        op_of = q[OP_MSB:OP_LSB];
    endfunction : op_of

    function automatic logic is_direct(input logic [15:0] q);
        is_direct = q[CONT_BIT];
    endfunction : is_direct

endpackage : bic_pkg

// ==== include/bic_scan_if.sv ====
/*
 * Link between the channel control and its storage-access ring stage.
 * Assumes both ends run on the same clock.
 */
interface bic_scan_if;
    logic need_set;
    logic abort;
    logic hold;
    logic done;

    modport chan  (output need_set, output abort, output hold, input done);
    modport stage (input need_set, input abort, input hold, output done);
endinterface : bic_scan_if

// ==== hw/bic_scan_stage.sv ====
/*
 * One stage of the distributed storage-access ring scanner, with the
 * access-need, ring-halt and resume flags.
 * Assumes the ring neighbour inputs are synchronous to sys_clk_i.
 */
module bic_scan_stage
    import bic_pkg::*;
(
    input  wire logic       sys_clk_i,    // System clock
    input  wire logic       rst_i,        // Sync reset, high
    input  wire logic       mclr_i,       // Host master clear
    input  wire logic       scan_in_i,    // Ring input
    input  wire logic [2:0] ring_pos_i,   // Ring position select
    input  wire logic       mem_resume_i, // Storage resume
    output logic            mem_req_o,    // Storage request
    output logic            scan_out_o,   // Ring output
    bic_scan_if.stage       sb            // Channel side
);

    bic_scan_st_t s;
    bic_scan_st_t n;
    logic         grant;
    logic         lone;
    logic         lead;
    logic         off;
    logic         src;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n     = s;
        grant = s.halt & mem_resume_i;
        lone  = (ring_pos_i == POS_ONE);
        off   = (ring_pos_i == POS_OUT);
        // Middle, last and unknown codes just copy the neighbour
        lead  = (ring_pos_i == POS_FIRST) | lone;
        // A lone unit closes the ring on itself
        src   = lone ? s.scan : scan_in_i;
        n.resm = grant;
        if (grant) begin
            n.need = 1'b0;
            n.halt = 1'b0;
        end else if (s.need && s.scan) begin
            n.halt = 1'b1;
        end
        if (sb.abort) begin
            n.need = 1'b0;
            n.halt = 1'b0;
        end
        if (sb.need_set) begin
            n.need = 1'b1;
        end
        // Need also blocks clearing so the token cannot slip past
        // in the cycle before the halt flag is up
        if (off) begin
            n.scan = 1'b0;
        end else if (s.scan && (s.halt || s.need || sb.hold)) begin
            n.scan = 1'b1;
        end else begin
            n.scan = lead ? ~src : src;
        end
        n.out = off ? scan_in_i : n.scan;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || mclr_i) begin
            s <= SCAN_RST;
        end else begin
            s <= n;
        end
    end

    assign mem_req_o  = s.halt;
    assign scan_out_o = s.out;
    assign sb.done    = s.resm;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i || mclr_i);

    a_need_halts_ring: assert property (
        s.need && s.scan && !s.halt && !sb.abort |=> s.halt && s.scan)
        else $error("halt not set on need with scanner stage");

    a_resume_clears_flags: assert property (
        grant && !sb.need_set && !sb.abort |=> !s.need && !s.halt)
        else $error("resume did not clear need and halt");

    a_resume_restarts: assert property (
        grant |=> sb.done ##1 !sb.done)
        else $error("resume flag not a single pulse");

    a_hold_keeps_stage: assert property (
        s.scan && sb.hold && ring_pos_i != POS_OUT |=> s.scan)
        else $error("scanner stage cleared under priority");

endmodule : bic_scan_stage

// ==== test/bic_far_model.sv ====
/* Far side of the channel: storage granting after a random wait, and a
   peripheral that accepts every strobe. Assumes one shared clock. */
module bic_far_model (
    input  wire logic        clk_i,        // System clock
    input  wire logic        req_i,        // Storage request
    input  wire logic [15:0] addr_i,       // Storage address
    input  wire logic        stb_i,        // Read or write strobe
    output logic             res_o = 1'b0, // Storage grant
    output logic      [15:0] data_o,       // Storage read data
    output logic             ack_o = 1'b0  // Peripheral accept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic late = 1'b0;
    // Word at a holds a+3, so a block start holds its own end address;
    // it stands with the grant and the cycle after, when it is latched
    assign data_o = (res_o | late) ? addr_i + 16'h0003 : ~addr_i;
    always @(posedge clk_i) begin
        late  <= res_o;
        res_o <= req_i & ~res_o & 1'($urandom_range(1));
        ack_o <= stb_i & (ack_o | 1'($urandom_range(1)));
    end
endmodule : bic_far_model

// ==== test/bic_channel_tb.sv ====
/* Self-checking bench: host requests, storage and peripheral model.
   Assumes the channel is a lone ring stage looped onto itself. */
module bic_channel_tb
    import bic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, rst_i = 1, mclr_i = 0, host_wr_i = 0, host_rd_i = 0;
    logic [15:0] host_q_i = '0, host_a_i = '0, per_data_i = '0, host_a_o;
    logic [15:0] per_q_o, per_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic per_reply_i, per_reject_i = 0, per_priority_i = 0, wseen = 0;
    logic mem_protect_i = 0, mem_resume_i, host_reply_o, host_reject_o;
    logic per_read_o, per_write_o, buf_active_o, priority_o, mem_req_o;
    logic mem_we_o, ctl_word_o, scan_out_o;
    logic [2:0] ring_pos_i = POS_ONE;
    wire logic scan_in_i = scan_out_o;
    logic [17:0] hexp[$], e;
    logic [31:0] pexp[$], p;
    logic [15:0] s, d, dq;
    int err_total = 0, checked = 0;
    bic_channel i_bic_channel (.*);
    bic_far_model i_bic_far_model (.clk_i(sys_clk_i), .req_i(mem_req_o),
        .addr_i(mem_addr_o), .stb_i(per_read_o | per_write_o),
        .res_o(mem_resume_i), .data_o(mem_rdata_i), .ack_o(per_reply_i));
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // Entry: bit 17 refusal, bit 16 compare data, low half the word
    task automatic op(input logic r, input logic [15:0] q, a,
                      input logic [17:0] x);
        @(posedge sys_clk_i);
        host_rd_i <= r;
        host_wr_i <= ~r;
        host_q_i <= q;
        host_a_i <= a;
        hexp.push_back(x);
        @(posedge sys_clk_i);
        host_rd_i <= 1'b0;
        host_wr_i <= 1'b0;
    endtask : op
    task automatic settle(input string n);
        int i;
        for (i = 0; i < 3000 && (hexp.size() > 0 || buf_active_o !== 1'b0
             || per_write_o !== 1'b0 || per_reply_i !== 1'b0); i++)
            @(posedge sys_clk_i);
        if (i == 3000) begin
            err_total++;
            stop_test();
        end else begin
            $display("test %s done", n);
        end
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i) begin
        wseen <= per_write_o;
        if (per_write_o & ~wseen) begin
            p = pexp.pop_front();
            chk(per_data_o, p[15:0]);
            chk(per_q_o, p[31:16]);
        end
        if (mem_req_o & mem_resume_i) begin
            chk(16'(buf_active_o), 16'h0001);
            if (mem_we_o) begin
                p = pexp.pop_front();
                chk(mem_wdata_o, p[15:0]);
                chk(mem_addr_o, p[31:16]);
                chk(16'(priority_o), 16'h0001);
            end
        end
        if (host_reply_o | host_reject_o) begin
            e = hexp.pop_front();
            chk(16'(host_reject_o), 16'(e[17]));
            if (e[16]) chk(host_a_o, e[15:0]);
        end
    end
    initial begin
        void'($urandom(32'hf42c8796));
        s = 16'($urandom) & 16'h0ff0;
        d = 16'($urandom);
        dq = 16'h8000 | 16'($urandom);
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        per_data_i <= d;
        op(1'b1, 16'h2000, 16'h0000, 18'h10001);
        settle("status");
        pexp.push_back({16'h1000, s + 16'h0004});
        pexp.push_back({16'h1000, s + 16'h0005});
        op(1'b0, 16'h1000, s, 18'h00000);
        op(1'b0, 16'h1000, s, 18'h20000);
        op(1'b0, dq, d, 18'h20000);
        settle("block out");
        op(1'b1, 16'h1800, 16'h0000, {2'b01, s + 16'h0003});
        settle("current address");
        op(1'b1, 16'h2000, 16'h0000, 18'h10215);
        settle("end status");
        pexp.push_back({dq, d});
        op(1'b0, dq, d, 18'h00000);
        settle("direct out");
        op(1'b1, dq, 16'h0000, {2'b01, d});
        settle("direct in");
        per_reject_i <= 1'b1;
        pexp.push_back({dq, d});
        op(1'b0, dq, d, 18'h20000);
        settle("refused out");
        per_reject_i <= 1'b0;
        per_priority_i <= 1'b1;
        mem_protect_i <= 1'b1;
        pexp.push_back({s + 16'h0101, d});
        pexp.push_back({s + 16'h0102, d});
        op(1'b0, 16'h0800, s + 16'h0100, 18'h00000);
        settle("block in");
        chk(16'(priority_o), 16'h0000);
        per_priority_i <= 1'b0;
        mem_protect_i <= 1'b0;
        op(1'b0, 16'h2800, 16'h0000, {2'b01, s + 16'h0103});
        settle("terminate");
        op(1'b1, 16'h2000, 16'h0000, 18'h10255);
        settle("in status");
        op(1'b1, 16'h2000, 16'h0000, 18'h10201);
        settle("status clear");
        mclr_i <= 1'b1;
        @(posedge sys_clk_i);
        mclr_i <= 1'b0;
        op(1'b1, 16'h2000, 16'h0000, 18'h10001);
        settle("master clear");
        stop_test();
    end
endmodule : bic_channel_tb
